// ==== rtl/bcrc_fifo.sv ====
// Holds no logic: the valid/ready FIFO module sits beside the engine in the engine's file

// ==== rtl/bcrc_pkg.sv ====
// Constants and carrier types for the byte CRC16 engine
// Operation
// - Remainder updates with CCITT-16 generator polynomial 0x1021 for every input byte, except one leaving the FIFO in a seed-load cycle, which is dropped.
// - Bytes are folded one at a time; 16-bit result held in a register.
// - Starting value is loaded before a run, either 0x0000 or 0xFFFF.
// - On request, flash is read autonomously over one or more 256-byte blocks.
package bcrc_pkg;
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam logic [15:0] SEED_ZERO     = 16'h0000;
	localparam logic [15:0] SEED_ONES     = 16'hffff;
	localparam int          BLOCK_BYTES   = 256;
	localparam int          FIFO_DEPTH    = 32;
	localparam int          BYTE_W        = 8;
	localparam int          FLASH_AW      = 16;
	localparam int          BLKCNT_W      = 8;

	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic              reverse;
	} bcrc_byte_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_REQ  = 3'h2,
		ST_WAIT = 3'h4
	} bcrc_state_t;
endpackage : bcrc_pkg

// ==== rtl/byte_crc16_engine.sv ====
// Byte CRC16 engine with software byte feed and autonomous flash scan
module bcrc_engine
	import bcrc_pkg::*;
(
	input  wire logic                ref_clk,     // 50 MHz system clock
	input  wire logic                rst,         // Async reset, active high
	input  wire logic                seedLoad,    // Pulse: load seed
	input  wire logic                seedOnes,    // Seed select: 1 = all ones
	input  wire logic                bitReverse,  // Reverse bits within byte
	input  wire logic [BYTE_W-1:0]   swData,      // Software byte
	input  wire logic                swValid,     // Software byte valid
	output logic                     swReady,     // Software byte accepted
	input  wire logic                autoStart,   // Pulse: start flash scan
	input  wire logic [FLASH_AW-9:0] autoBlock,   // First 256-byte block
	input  wire logic [BLKCNT_W-1:0] autoCount,   // Blocks minus one
	output logic                     autoBusy,    // Flash scan in progress
	output logic                     flashRd,     // Flash read strobe
	output logic [FLASH_AW-1:0]      flashAddr,   // Flash byte address
	input  wire logic [BYTE_W-1:0]   flashData,   // Flash read data
	input  wire logic                flashValid,  // Flash data returned
	output logic [15:0]              crcResult,   // Running checksum
	output logic                     crcIdle      // FIFO drained
);
	bcrc_state_t               st_ff, nxt_st;
	logic [FLASH_AW-1:0]       addr_ff, nxt_addr;
	logic [FLASH_AW-1:0]       endAddr_ff, nxt_endAddr;
	logic [15:0]               crc_ff, nxt_crc;
	bcrc_byte_t                fIn, fOut;
	logic                      fInValid, fInReady, fOutValid;
	logic                      scanTake, scanLast;

	function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction : crcByte

	function automatic logic [7:0] revByte(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = d[7-i];
		return r;
	endfunction : revByte

	function automatic logic [FLASH_AW-1:0] blockBase(input logic [FLASH_AW-9:0] blk);
		return {blk, 8'h00};
	endfunction : blockBase

	// Flash bytes take priority; software stalls during a scan
	always_comb
	begin
		fIn.reverse = bitReverse;
		fIn.data    = autoBusy ? flashData : swData;
		// A stray strobe outside WAIT must not push a byte
		fInValid    = autoBusy ? ((st_ff == ST_WAIT) && flashValid) : swValid;
		swReady     = !autoBusy && fInReady;
	end

	// A returned byte is consumed only when the FIFO can take it
	always_comb
	begin
		scanTake = (st_ff == ST_WAIT) && flashValid && fInReady;
		scanLast = (addr_ff == endAddr_ff);
	end

	bcrc_fifo #(
		.WIDTH($bits(bcrc_byte_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.inData  (fIn),
		.inValid (fInValid),
		.inReady (fInReady),
		.outData (fOut),
		.outValid(fOutValid),
		.outReady(1'b1)
	);

	always_comb
	begin
		nxt_crc = crc_ff;
		if (fOutValid)
			nxt_crc = crcByte(crc_ff, fOut.reverse ? revByte(fOut.data) : fOut.data);
		// Seed wins over a byte folding in the same cycle
		if (seedLoad)
			nxt_crc = seedOnes ? SEED_ONES : SEED_ZERO;
	end

	// Scan issues one read at a time, only while the FIFO has room
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_addr    = addr_ff;
		nxt_endAddr = endAddr_ff;
		case (st_ff)
			ST_IDLE:
			begin
				if (autoStart)
				begin
					nxt_addr    = blockBase(autoBlock);
					// End address wraps at the top of the 64 KB space
					nxt_endAddr = blockBase(autoBlock) + FLASH_AW'((32'(autoCount) + 1) * BLOCK_BYTES - 1);
					nxt_st      = ST_REQ;
				end
			end
			ST_REQ:
			begin
				if (fInReady)
					nxt_st = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (scanTake)
				begin
					nxt_addr = addr_ff + 1'b1;
					nxt_st   = scanLast ? ST_IDLE : ST_REQ;
				end
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	// Scan state
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff      <= ST_IDLE;
			addr_ff    <= '0;
			endAddr_ff <= '0;
		end
		else
		begin
			st_ff      <= nxt_st;
			addr_ff    <= nxt_addr;
			endAddr_ff <= nxt_endAddr;
		end
	end

	// Checksum state; reset value equals the zero seed
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			crc_ff <= SEED_ZERO;
		end
		else
		begin
			crc_ff <= nxt_crc;
		end
	end

	assign autoBusy  = (st_ff != ST_IDLE);
	assign flashRd   = (st_ff == ST_REQ) && fInReady;
	assign flashAddr = addr_ff;
	assign crcResult = crc_ff;
	// Seed loads do not flush the FIFO, so software waits for this
	assign crcIdle   = !fOutValid && !autoBusy;
endmodule : bcrc_engine

// Parameterised valid/ready FIFO
module bcrc_fifo
	import bcrc_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
)(
	input  wire logic             ref_clk,  // System clock
	input  wire logic             rst,      // Async reset
	input  wire logic [WIDTH-1:0] inData,   // Write data
	input  wire logic             inValid,  // Write valid
	output logic                  inReady,  // Not full
	output logic      [WIDTH-1:0] outData,  // Head data
	output logic                  outValid, // Not empty
	input  wire logic             outReady  // Read accept
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0]      count_ff, nxt_count;
	logic             doWr, doRd;

	// Count is one bit wider than the pointers so full and empty differ
	always_comb
	begin
		inReady   = (count_ff != (AW+1)'(DEPTH));
		outValid  = (count_ff != '0);
		doWr      = inValid && inReady;
		doRd      = outValid && outReady;
		nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
		nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
		nxt_count = count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
	end

	// Storage has no reset; validity is tracked by count
	always_ff @(posedge ref_clk)
	begin
		if (doWr)
			mem[wrPtr_ff] <= inData;
	end

	assign outData = mem[rdPtr_ff];
endmodule : bcrc_fifo

// ==== sim/bcrc_checker.sv ====
// Port assertions for the byte CRC16 engine
module bcrc_checker
	import bcrc_pkg::*;
(
	input wire logic                ref_clk,    // Clock
	input wire logic                rst,        // Reset
	input wire logic                seedLoad,   // Seed pulse
	input wire logic                seedOnes,   // Seed select
	input wire logic                bitReverse, // Reverse select
	input wire logic [BYTE_W-1:0]   swData,     // Byte data
	input wire logic                swValid,    // Byte valid
	input wire logic                swReady,    // Byte ready
	input wire logic                autoStart,  // Scan start
	input wire logic [FLASH_AW-9:0] autoBlock,  // First block
	input wire logic                autoBusy,   // Scan busy
	input wire logic                flashRd,    // Read strobe
	input wire logic [FLASH_AW-1:0] flashAddr,  // Read address
	input wire logic [15:0]         crcResult,  // Checksum
	input wire logic                crcIdle     // Drained
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Bitwise reference, independent of the engine's datapath
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d, input logic rev);
		logic [7:0] b;
		for (int k = 0; k < 8; k++)
			b[k] = rev ? d[7-k] : d[k];
		for (int k = 7; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : crcStep
	seed_load_a: assert property (seedLoad && crcIdle |=>
		crcResult == ($past(seedOnes) ? SEED_ONES : SEED_ZERO))
		else $error("seed not loaded");
	result_hold_a: assert property (crcIdle && !seedLoad && !(swValid && swReady) |=>
		$stable(crcResult))
		else $error("result moved while idle");
	fold_step_a: assert property (swValid && swReady && crcIdle ##1 !seedLoad |=>
		crcResult == crcStep($past(crcResult), $past(swData, 2), $past(bitReverse, 2)))
		else $error("byte fold wrong");
	scan_start_a: assert property (autoStart && crcIdle |=>
		autoBusy && flashRd && flashAddr == {$past(autoBlock), 8'h00})
		else $error("scan start wrong");
	one_read_a: assert property (flashRd |=> !flashRd)
		else $error("second read while one outstanding");
	addr_hold_a: assert property (flashRd |=> $stable(flashAddr))
		else $error("address moved before data");
	busy_refuse_a: assert property (autoBusy |-> !swReady)
		else $error("byte taken during scan");
	read_busy_a: assert property (flashRd |-> autoBusy)
		else $error("read outside scan");
endmodule : bcrc_checker

bind bcrc_engine bcrc_checker i_chk (
	.ref_clk   (ref_clk),
	.rst       (rst),
	.seedLoad  (seedLoad),
	.seedOnes  (seedOnes),
	.bitReverse(bitReverse),
	.swData    (swData),
	.swValid   (swValid),
	.swReady   (swReady),
	.autoStart (autoStart),
	.autoBlock (autoBlock),
	.autoBusy  (autoBusy),
	.flashRd   (flashRd),
	.flashAddr (flashAddr),
	.crcResult (crcResult),
	.crcIdle   (crcIdle)
);

// ==== sim/tb.sv ====
// Random and corner tests of the byte CRC16 engine
module tb import bcrc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst = 1, seedLoad = 0, seedOnes = 0, bitReverse = 0;
	logic swValid = 0, autoStart = 0, flashValid = 0;
	logic [7:0] swData = 0, autoBlock = 0, autoCount = 0, flashData = 0;
	logic [15:0] exp, a;
	wire logic swReady, autoBusy, flashRd, crcIdle;
	wire logic [15:0] flashAddr, crcResult;
	int miscompares = 0, tests_run = 0, i, reads = 0, rd0;
	bcrc_engine i_dut (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.seedLoad  (seedLoad),
		.seedOnes  (seedOnes),
		.bitReverse(bitReverse),
		.swData    (swData),
		.swValid   (swValid),
		.swReady   (swReady),
		.autoStart (autoStart),
		.autoBlock (autoBlock),
		.autoCount (autoCount),
		.autoBusy  (autoBusy),
		.flashRd   (flashRd),
		.flashAddr (flashAddr),
		.flashData (flashData),
		.flashValid(flashValid),
		.crcResult (crcResult),
		.crcIdle   (crcIdle)
	);
	initial forever #10 ref_clk = ~ref_clk;
	// Flash answers next cycle; data line scrambles when idle
	always @(posedge ref_clk)
	begin
		flashValid <= flashRd;
		flashData <= flashRd ? flashAddr[7:0] ^ flashAddr[15:8] : ~flashData;
		if (flashRd)
			reads <= reads + 1;
	end
	function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] b, logic r);
		logic [7:0] t;
		t = b;
		for (int k = 0; k < 8; k++)
			if (r) t[k] = b[7-k];
		for (int k = 7; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ t[k]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : fold
	task check(logic [15:0] got, logic [15:0] want);
		tests_run++;
		if (got !== want)
		begin
			$display("CHECK FAILED %0t %h %h", $time, got, want);
			miscompares++;
		end
	endtask : check
	task send(logic [7:0] b, logic r);
		swData <= b;
		bitReverse <= r;
		swValid <= 1;
		@(posedge ref_clk);
		while (swReady !== 1'b1) @(posedge ref_clk);
		exp = fold(exp, b, r);
	endtask : send
	task seed(logic o);
		@(posedge ref_clk) seedLoad <= 1;
		seedOnes <= o;
		@(posedge ref_clk) seedLoad <= 0;
		exp = o ? SEED_ONES : SEED_ZERO;
	endtask : seed
	task scan(logic [7:0] blk, logic [7:0] cnt, logic r);
		for (i = 0; i < (int'(cnt) + 1) * BLOCK_BYTES; i++)
		begin
			a = {blk, 8'h00} + i[15:0];
			exp = fold(exp, a[7:0] ^ a[15:8], r);
		end
		rd0 = reads;
		@(posedge ref_clk) autoBlock <= blk;
		autoCount <= cnt;
		bitReverse <= r;
		autoStart <= 1'b1;
		@(posedge ref_clk) autoStart <= 1'b0;
		// Busy shows only after the edge that takes the start
		@(posedge ref_clk);
		for (i = 0; i < 3000 && autoBusy !== 1'b0; i++) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		check(crcResult, exp);
		check(16'(reads - rd0), 16'((int'(cnt) + 1) * BLOCK_BYTES));
		check(16'(crcIdle), 16'h0001);
	endtask : scan
	task summarize;
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		#200000 miscompares++;
		summarize;
	end
	initial
	begin
		void'($urandom(74622));
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		check(crcResult, 16'h0000);
		for (int s = 0; s < 2; s++)
		begin
			seed(s[0]);
			@(posedge ref_clk);
			send(8'h01, 1);
			for (i = 0; i < 20; i++) send(8'($urandom), 1'($urandom));
			swValid <= 0;
			repeat (3) @(posedge ref_clk);
			check(crcResult, exp);
		end
		// Top block plus one: address wraps past 64K
		seed(1);
		scan(8'hff, 8'h01, 1'b1);
		// Single random block, bytes unreversed
		seed(0);
		scan(8'($urandom), 8'h00, 1'b0);
		summarize;
	end
endmodule : tb
